// ### acmcfg_pkg.sv
package acmcfg_pkg;

  // Register offsets on the internal register port
  localparam logic [7:0] ADDR_DEVICE_CONFIG = 8'h0B;
  localparam logic [7:0] ADDR_AXIS_CONFIG_X = 8'h0C;
  localparam logic [7:0] ADDR_AXIS_CONFIG_Y = 8'h0D;
  localparam logic [7:0] ADDR_ARM_CONFIG_X  = 8'h0E;
  localparam logic [7:0] ADDR_ARM_CONFIG_Y  = 8'h0F;

  // Reset values
  localparam logic [7:0] RST_DEVICE_CONFIG = 8'h00;
  localparam logic [7:0] RST_AXIS_CONFIG   = 8'h00;
  localparam logic [7:0] RST_ARM_CONFIG    = 8'h0F;

  // Device configuration fields
  localparam int unsigned DCFG_LOCK_BIT   = 5;
  localparam int unsigned DCFG_FORMAT_BIT = 4;
  localparam int unsigned DCFG_OFFSET_MONITOR_EN_BIT  = 3;
  localparam int unsigned DCFG_MODE_LSB   = 0;
  localparam int unsigned DCFG_MODE_W     = 3;

  // Axis configuration fields
  localparam int unsigned AXIS_ST_BIT     = 7;
  localparam int unsigned AXIS_FILT_LSB   = 0;
  localparam int unsigned AXIS_FILT_W     = 4;
  localparam int unsigned FILT_SLOW_BIT   = 3;
  localparam logic [2:0]  FILT_3POLE_LOW  = 3'h5;
  localparam logic [2:0]  FILT_LAST_LOW   = 3'h5;

  // Arming configuration fields
  localparam int unsigned ARM_STRETCH_LSB = 4;
  localparam int unsigned ARM_NEG_LSB     = 2;
  localparam int unsigned ARM_POS_LSB     = 0;

  // Zero-g output codes
  localparam logic [9:0] ZERO_CODE_UNSIGNED = 10'h200;
  localparam logic [9:0] ZERO_CODE_SIGNED   = 10'h000;

  // Timing: clock rate and offset monitor blanking after self-test
  localparam int unsigned CLK_KHZ           = 40000;
  localparam int unsigned SELFTEST_BLANK_US = 1000;
  localparam int unsigned SELFTEST_BLANK_CYC = SELFTEST_BLANK_US * CLK_KHZ / 1000;
  localparam int unsigned BLANK_CNT_W       = 24;

  typedef enum logic [2:0] {
    ACM_ARM_OFF      = 3'b000,
    ACM_ARM_PCM      = 3'b001,
    ACM_ARM_MAVG_HI  = 3'b010,
    ACM_ARM_MAVG_LO  = 3'b011,
    ACM_ARM_COUNT_HI = 3'b100,
    ACM_ARM_COUNT_LO = 3'b101,
    ACM_ARM_UNF_HI   = 3'b110,
    ACM_ARM_UNF_LO   = 3'b111
  } acm_arm_mode_t;

  typedef struct packed {
    logic [3:0] filter_sel;
    logic       filt_valid;
    logic       filt_slow;
    logic       filt_three_pole;
    logic [1:0] stretch_sel;
    logic [1:0] neg_window_sel;
    logic [1:0] pos_window_sel;
  } acm_axis_cfg_t;

endpackage

// ### acmcfg_blank_timer.sv
`timescale 1ns/1ps
module acmcfg_blank_timer #(
  parameter logic [23:0] BLANK_CYC = 24'h00_9C40
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic start,
  output logic      busy
);

  logic [23:0] cnt_r;
  wire  [23:0] cnt_nxt = start ? BLANK_CYC : (cnt_r != 24'h00_0000) ? cnt_r - 24'h00_0001 : cnt_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt_r <= 24'h00_0000;
    else
      cnt_r <= cnt_nxt;
  end

  assign busy = (cnt_r != 24'h00_0000);

endmodule

// ### acmcfg_top.sv
// Operation
// - Format bit one gives unsigned results, zero-g nominal code 512.
// - Format bit zero gives signed results, zero-g nominal code zero.
// - Offset monitor runs only while its enable bit is one.
// - Three-bit mode field selects arming pin mode for both axes.
// - In filtered/unfiltered modes low bit picks polarity and pull current.
// - Axis configuration writes accepted only before init-done is set.
// - Axis and arming configuration registers are covered by the checksum.
// - Self-test bit seven enables positive self-test only while init-done clear.
// - Every internal reset clears both self-test enable bits.
// - Active self-test suspends offset cancel and monitor, status reports it.
// - After self-test clears, monitor blanked for interval, status clears at once.
// - Filter codes 0 to 5 select the fast 8 us filters.
// - Filter codes 8 to 13 select the slow 16 us filters.
// - Arming configuration matters only in moving average or count mode.
// - Arming register: stretch bits 5:4, negative window 3:2, positive 1:0.
// - Arming configuration writes accepted only before init-done is set.
// - Init-done write-protects config registers and clears only by reset.
// - Checksum comparison runs only while init-done is set.
`timescale 1ns/1ps
module acmcfg_top #(
  parameter int unsigned BLANK_CYC = acmcfg_pkg::SELFTEST_BLANK_CYC
) (
  // Clock and reset
  input  wire logic                     CLK,
  input  wire logic                     RST_N,
  // Register port from the serial interface decoder
  input  wire logic                     REG_WR,
  input  wire logic                     REG_RD,
  input  wire logic [7:0]               REG_ADDR,
  input  wire logic [7:0]               REG_WDATA,
  output logic [7:0]                    REG_RDATA,
  output logic                          REG_RVALID,
  // Data format
  output logic                          DATA_UNSIGNED,
  output logic [9:0]                    ZERO_CODE,
  // Offset and self-test control
  output logic                          OFFSET_MON_EN,
  output logic                          OFFSET_CANCEL_HOLD,
  output logic                          SELFTEST_STATUS,
  output logic                          X_SELFTEST_EN,
  output logic                          Y_SELFTEST_EN,
  // Per-axis configuration
  output acmcfg_pkg::acm_axis_cfg_t     X_CFG,
  output acmcfg_pkg::acm_axis_cfg_t     Y_CFG,
  // Arming pin configuration
  output acmcfg_pkg::acm_arm_mode_t     ARM_MODE,
  output logic                          ARM_OUT_EN,
  output logic                          ARM_ACTIVE_LOW,
  output logic                          ARM_PULLUP_EN,
  output logic                          ARM_PULLDOWN_EN,
  output logic                          ARM_PARAM_USE,
  // Lock and checksum
  output logic                          INIT_DONE,
  output logic                          CRC_CHECK_EN,
  output logic [39:0]                   CRC_IMAGE
);

  logic [7:0] dcfg_r;
  logic [7:0] axx_r;
  logic [7:0] axy_r;
  logic [7:0] amx_r;
  logic [7:0] amy_r;
  logic       st_act_r;

  // Address decode
  wire lock      = dcfg_r[acmcfg_pkg::DCFG_LOCK_BIT];
  wire wr_ok     = REG_WR && !lock;
  wire sel_dcfg  = (REG_ADDR == acmcfg_pkg::ADDR_DEVICE_CONFIG);
  wire sel_axx   = (REG_ADDR == acmcfg_pkg::ADDR_AXIS_CONFIG_X);
  wire sel_axy   = (REG_ADDR == acmcfg_pkg::ADDR_AXIS_CONFIG_Y);
  wire sel_amx   = (REG_ADDR == acmcfg_pkg::ADDR_ARM_CONFIG_X);
  wire sel_amy   = (REG_ADDR == acmcfg_pkg::ADDR_ARM_CONFIG_Y);

  // Init-done is sticky; only reset brings it back to zero
  wire [7:0] dcfg_nxt = (wr_ok && sel_dcfg) ?
                        (REG_WDATA | (dcfg_r & (8'h01 << acmcfg_pkg::DCFG_LOCK_BIT))) :
                        dcfg_r;
  wire [7:0] axx_nxt  = (wr_ok && sel_axx) ? REG_WDATA : axx_r;
  wire [7:0] axy_nxt  = (wr_ok && sel_axy) ? REG_WDATA : axy_r;
  wire [7:0] amx_nxt  = (wr_ok && sel_amx) ? REG_WDATA : amx_r;
  wire [7:0] amy_nxt  = (wr_ok && sel_amy) ? REG_WDATA : amy_r;

  // Read mux: unmapped offsets return zero
  wire [7:0] rd_mux = sel_dcfg ? dcfg_r :
                      sel_axx  ? axx_r  :
                      sel_axy  ? axy_r  :
                      sel_amx  ? amx_r  :
                      sel_amy  ? amy_r  : 8'h00;

  // Self-test only takes effect while still initialising
  wire st_x      = axx_r[acmcfg_pkg::AXIS_ST_BIT] && !lock;
  wire st_y      = axy_r[acmcfg_pkg::AXIS_ST_BIT] && !lock;
  wire st_act    = st_x || st_y;
  wire st_fall   = st_act_r && !st_act;
  wire blank_busy;

  acmcfg_blank_timer #(
    .BLANK_CYC (BLANK_CYC[23:0])
  ) u_blank (
    .clk   (CLK),
    .rst_n (RST_N),
    .start (st_fall),
    .busy  (blank_busy)
  );

  // Monitor stays off through self-test and the blanking tail that follows;
  // the falling edge itself is masked because the timer only loads on it
  wire offset_monitor_en_nxt = dcfg_r[acmcfg_pkg::DCFG_OFFSET_MONITOR_EN_BIT] && !st_act &&
                   !st_fall && !blank_busy;

  wire       fmt_uns  = dcfg_r[acmcfg_pkg::DCFG_FORMAT_BIT];
  wire [9:0] zero_nxt = fmt_uns ? acmcfg_pkg::ZERO_CODE_UNSIGNED :
                                  acmcfg_pkg::ZERO_CODE_SIGNED;

  // Arming pin mode
  wire [2:0] mode_raw = dcfg_r[acmcfg_pkg::DCFG_MODE_LSB +: acmcfg_pkg::DCFG_MODE_W];
  acmcfg_pkg::acm_arm_mode_t mode_nxt;
  logic mode_filtered;
  logic mode_polar;

  always_comb
  begin
    mode_nxt      = acmcfg_pkg::acm_arm_mode_t'(mode_raw);
    mode_filtered = 1'b0;
    mode_polar    = 1'b0;
    case (mode_nxt)
      acmcfg_pkg::ACM_ARM_OFF,
      acmcfg_pkg::ACM_ARM_PCM:
      begin
        mode_filtered = 1'b0;
        mode_polar    = 1'b0;
      end
      acmcfg_pkg::ACM_ARM_MAVG_HI,
      acmcfg_pkg::ACM_ARM_MAVG_LO,
      acmcfg_pkg::ACM_ARM_COUNT_HI,
      acmcfg_pkg::ACM_ARM_COUNT_LO:
      begin
        mode_filtered = 1'b1;
        mode_polar    = 1'b1;
      end
      acmcfg_pkg::ACM_ARM_UNF_HI,
      acmcfg_pkg::ACM_ARM_UNF_LO:
      begin
        mode_filtered = 1'b0;
        mode_polar    = 1'b1;
      end
      default:
      begin
        mode_filtered = 1'b0;
        mode_polar    = 1'b0;
      end
    endcase
  end

  wire arm_low_nxt  = mode_polar && mode_raw[0];
  wire arm_high_nxt = mode_polar && !mode_raw[0];

  // Per-axis decode, one instance of the same logic for X and Y
  acmcfg_pkg::acm_axis_cfg_t axis_nxt [2];
  wire [7:0] ax_src [2];
  wire [7:0] am_src [2];
  assign ax_src[0] = axx_r;
  assign ax_src[1] = axy_r;
  assign am_src[0] = amx_r;
  assign am_src[1] = amy_r;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_axis
      wire [3:0] fsel = ax_src[gi][acmcfg_pkg::AXIS_FILT_LSB +: acmcfg_pkg::AXIS_FILT_W];
      // Codes 6, 7, 14, 15 are flagged invalid; filters must not trust them
      assign axis_nxt[gi].filter_sel      = fsel;
      assign axis_nxt[gi].filt_valid      = (fsel[2:0] <= acmcfg_pkg::FILT_LAST_LOW);
      assign axis_nxt[gi].filt_slow       = fsel[acmcfg_pkg::FILT_SLOW_BIT];
      assign axis_nxt[gi].filt_three_pole = (fsel[2:0] == acmcfg_pkg::FILT_3POLE_LOW);
      // Arming parameters are masked outside moving average and count modes
      assign axis_nxt[gi].stretch_sel     = mode_filtered ?
               am_src[gi][acmcfg_pkg::ARM_STRETCH_LSB +: 2] : 2'b00;
      assign axis_nxt[gi].neg_window_sel  = mode_filtered ?
               am_src[gi][acmcfg_pkg::ARM_NEG_LSB +: 2] : 2'b00;
      assign axis_nxt[gi].pos_window_sel  = mode_filtered ?
               am_src[gi][acmcfg_pkg::ARM_POS_LSB +: 2] : 2'b00;
    end
  endgenerate

  // Checksum image: device, axis and arming configuration, low offset first
  wire [39:0] crc_nxt = {amy_r, amx_r, axy_r, axx_r, dcfg_r};

  // Configuration storage
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      dcfg_r <= acmcfg_pkg::RST_DEVICE_CONFIG;
      axx_r  <= acmcfg_pkg::RST_AXIS_CONFIG;
      axy_r  <= acmcfg_pkg::RST_AXIS_CONFIG;
      amx_r  <= acmcfg_pkg::RST_ARM_CONFIG;
      amy_r  <= acmcfg_pkg::RST_ARM_CONFIG;
    end
    else
    begin
      dcfg_r <= dcfg_nxt;
      axx_r  <= axx_nxt;
      axy_r  <= axy_nxt;
      amx_r  <= amx_nxt;
      amy_r  <= amy_nxt;
    end
  end

  // Read answer
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
    end
    else
    begin
      REG_RVALID <= REG_RD;
      if (REG_RD)
        REG_RDATA <= rd_mux;
    end
  end

  // Decoded outputs, registered one cycle behind the storage
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      st_act_r           <= 1'b0;
      DATA_UNSIGNED      <= 1'b0;
      ZERO_CODE          <= acmcfg_pkg::ZERO_CODE_SIGNED;
      OFFSET_MON_EN      <= 1'b0;
      OFFSET_CANCEL_HOLD <= 1'b0;
      SELFTEST_STATUS    <= 1'b0;
      X_SELFTEST_EN      <= 1'b0;
      Y_SELFTEST_EN      <= 1'b0;
      X_CFG              <= '0;
      Y_CFG              <= '0;
      ARM_MODE           <= acmcfg_pkg::ACM_ARM_OFF;
      ARM_OUT_EN         <= 1'b0;
      ARM_ACTIVE_LOW     <= 1'b0;
      ARM_PULLUP_EN      <= 1'b0;
      ARM_PULLDOWN_EN    <= 1'b0;
      ARM_PARAM_USE      <= 1'b0;
      INIT_DONE          <= 1'b0;
      CRC_CHECK_EN       <= 1'b0;
      CRC_IMAGE          <= '0;
    end
    else
    begin
      st_act_r           <= st_act;
      DATA_UNSIGNED      <= fmt_uns;
      ZERO_CODE          <= zero_nxt;
      OFFSET_MON_EN      <= offset_monitor_en_nxt;
      OFFSET_CANCEL_HOLD <= st_act;
      SELFTEST_STATUS    <= st_act;
      X_SELFTEST_EN      <= st_x;
      Y_SELFTEST_EN      <= st_y;
      X_CFG              <= axis_nxt[0];
      Y_CFG              <= axis_nxt[1];
      ARM_MODE           <= mode_nxt;
      ARM_OUT_EN         <= (mode_raw != 3'h0);
      ARM_ACTIVE_LOW     <= arm_low_nxt;
      ARM_PULLUP_EN      <= arm_low_nxt;
      ARM_PULLDOWN_EN    <= arm_high_nxt;
      ARM_PARAM_USE      <= mode_filtered;
      INIT_DONE          <= lock;
      CRC_CHECK_EN       <= lock;
      CRC_IMAGE          <= crc_nxt;
    end
  end

endmodule

// ### acmcfg_properties.sv
`timescale 1ns/1ps
module acmcfg_chk #(
  parameter int unsigned BLANK_CYC = acmcfg_pkg::SELFTEST_BLANK_CYC
) (
  // Clock and reset
  input wire logic                      CLK,
  input wire logic                      RST_N,
  // Register port
  input wire logic                      REG_RD,
  input wire logic                      REG_RVALID,
  // Decoded outputs
  input wire logic                      DATA_UNSIGNED,
  input wire logic [9:0]                ZERO_CODE,
  input wire logic                      OFFSET_MON_EN,
  input wire logic                      SELFTEST_STATUS,
  input wire logic                      X_SELFTEST_EN,
  input wire acmcfg_pkg::acm_axis_cfg_t X_CFG,
  input wire acmcfg_pkg::acm_arm_mode_t ARM_MODE,
  input wire logic                      ARM_OUT_EN,
  input wire logic                      ARM_ACTIVE_LOW,
  input wire logic                      ARM_PULLUP_EN,
  input wire logic                      ARM_PULLDOWN_EN,
  input wire logic                      ARM_PARAM_USE,
  input wire logic                      INIT_DONE,
  input wire logic                      CRC_CHECK_EN
);
  // Cycles since self-test last dropped, saturating
  logic [23:0] gap_r;
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      gap_r <= 24'hFF_FFFF;
    else if ($fell(SELFTEST_STATUS))
      gap_r <= 24'h00_0000;
    else if (gap_r != 24'hFF_FFFF)
      gap_r <= gap_r + 24'h00_0001;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  a_read_answer: assert property (REG_RD |=> REG_RVALID)
    else $error("read strobe not answered");
  a_answer_cause: assert property (REG_RVALID |-> $past(REG_RD))
    else $error("read answer without strobe");
  a_zero_code: assert property (ZERO_CODE == (DATA_UNSIGNED ? 10'h200 : 10'h000))
    else $error("zero code disagrees with format");
  a_pin_drive: assert property ((ARM_OUT_EN == (ARM_MODE != 3'h0))
    && (ARM_PARAM_USE == (ARM_MODE inside {[3'h2:3'h5]})))
    else $error("arming drive or parameter use wrong");
  a_pin_polarity: assert property ((ARM_ACTIVE_LOW == (ARM_MODE[2:1] != 2'h0 && ARM_MODE[0]))
    && (ARM_PULLUP_EN == ARM_ACTIVE_LOW)
    && (ARM_PULLDOWN_EN == (ARM_MODE[2:1] != 2'h0 && !ARM_MODE[0])))
    else $error("arming polarity wrong");
  a_param_mask: assert property (!ARM_PARAM_USE |-> X_CFG[5:0] == 6'h00)
    else $error("arming parameters leak");
  a_lock_sticky: assert property (INIT_DONE |=> INIT_DONE)
    else $error("lock dropped without reset");
  a_crc_gate: assert property (CRC_CHECK_EN == INIT_DONE)
    else $error("checksum enable not tied to lock");
  a_st_locked: assert property (INIT_DONE && $past(INIT_DONE) |-> !X_SELFTEST_EN)
    else $error("self-test active after lock");
  a_st_status: assert property (SELFTEST_STATUS |-> !OFFSET_MON_EN)
    else $error("monitor runs during self-test");
  a_mon_blank: assert property (OFFSET_MON_EN |-> gap_r >= BLANK_CYC - 1)
    else $error("monitor back before blanking ends");
  a_blank_start: assert property ($fell(SELFTEST_STATUS) |-> (!OFFSET_MON_EN) [*8])
    else $error("monitor glitch as self-test drops");
  c_read: cover property (REG_RVALID);
  c_st_drop: cover property ($fell(SELFTEST_STATUS));
  c_lock: cover property ($rose(INIT_DONE));
endmodule
bind acmcfg_top acmcfg_chk #(.BLANK_CYC(BLANK_CYC)) u_chk (
  .CLK(CLK), .RST_N(RST_N), .REG_RD(REG_RD), .REG_RVALID(REG_RVALID),
  .DATA_UNSIGNED(DATA_UNSIGNED), .ZERO_CODE(ZERO_CODE), .OFFSET_MON_EN(OFFSET_MON_EN),
  .SELFTEST_STATUS(SELFTEST_STATUS), .X_SELFTEST_EN(X_SELFTEST_EN), .X_CFG(X_CFG),
  .ARM_MODE(ARM_MODE), .ARM_OUT_EN(ARM_OUT_EN), .ARM_ACTIVE_LOW(ARM_ACTIVE_LOW),
  .ARM_PULLUP_EN(ARM_PULLUP_EN), .ARM_PULLDOWN_EN(ARM_PULLDOWN_EN),
  .ARM_PARAM_USE(ARM_PARAM_USE), .INIT_DONE(INIT_DONE), .CRC_CHECK_EN(CRC_CHECK_EN)
);

// ### acmcfg_host.sv
`timescale 1ns/1ps
module acmcfg_host (
  // Clock
  input  wire logic       clk,
  // Register port towards the device
  output logic            wr,
  output logic            rd,
  output logic [7:0]      addr,
  output logic [7:0]      wdata
);
  initial
  begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    wr = w;
    rd = !w;
    addr = a;
    // Reserved axis bits always leave as zero
    wdata = (w && a inside {8'h0C, 8'h0D}) ? (d & 8'h8F) : d;
    @(posedge clk);
    #1;
    wr = 1'b0;
    rd = 1'b0;
    // Released lines must not keep looking valid
    addr = ~a;
    wdata = ~wdata;
  endtask
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned BLANK = 20;
  logic                      clk;
  logic                      rst_n;
  logic                      wr, rd, rvalid, dunsig, mon_en, hold, st_stat, xst, yst;
  logic                      oen, alow, pu, pd, puse, idone, crc_en, pol, use_p;
  logic [7:0]                addr, wdata, rdata, lock_v;
  logic [2:0]                md;
  logic [9:0]                zcode;
  logic [39:0]               img, exp_img;
  logic [31:0]               r;
  logic [7:0]                exp_q[$];
  acmcfg_pkg::acm_axis_cfg_t xcfg, ycfg;
  acmcfg_pkg::acm_arm_mode_t amode;
  int                        seed = 32'hDEE0_1CF3;
  int                        failures = 0;
  int                        checks = 0;
  int                        n;
  acmcfg_top #(.BLANK_CYC(BLANK)) dut (
    .CLK(clk), .RST_N(rst_n), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .DATA_UNSIGNED(dunsig), .ZERO_CODE(zcode), .OFFSET_MON_EN(mon_en),
    .OFFSET_CANCEL_HOLD(hold), .SELFTEST_STATUS(st_stat), .X_SELFTEST_EN(xst),
    .Y_SELFTEST_EN(yst), .X_CFG(xcfg), .Y_CFG(ycfg), .ARM_MODE(amode),
    .ARM_OUT_EN(oen), .ARM_ACTIVE_LOW(alow), .ARM_PULLUP_EN(pu), .ARM_PULLDOWN_EN(pd),
    .ARM_PARAM_USE(puse), .INIT_DONE(idone), .CRC_CHECK_EN(crc_en), .CRC_IMAGE(img)
  );
  acmcfg_host u_host (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata));
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [7:0] got);
    logic [7:0] e;
    e = 8'hxx;
    if (exp_q.size() != 0)
      e = exp_q.pop_front();
    checks++;
    if (got !== e)
    begin
      failures++;
      $display("mismatch at %0t: read data %h expected %h", $time, got, e);
    end
  endtask
  task automatic wrs(input logic [7:0] a, input logic [7:0] d);
    u_host.access(1'b1, a, d);
    repeat (2) @(posedge clk);
    #2;
  endtask
  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_host.access(1'b0, a, 8'h00);
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(negedge clk)
  begin
    if (rvalid === 1'b1)
      chk_rd(rdata);
  end
  initial
  begin
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    // Reset values, then the unused control offset and an unmapped one
    exp_img = 40'h0F_0F00_0000;
    for (int i = 0; i < 5; i++)
      rd_exp(8'h0B + i[7:0], exp_img[8*i +: 8]);
    rd_exp(8'h0A, 8'h00);
    rd_exp(8'h20, 8'h00);
    wrs(8'h0E, 8'h39);
    wrs(8'h0F, 8'h06);
    for (int m = 0; m < 8; m++)
    begin
      md = m[2:0];
      pol = md[2:1] != 2'h0;
      use_p = md inside {[3'h2:3'h5]};
      wrs(8'h0B, {3'h0, md[1], md[2], md});
      chk(amode, md, "mode");
      chk(oen, md != 3'h0, "drive");
      chk({alow, pu, pd}, {pol & md[0], pol & md[0], pol & !md[0]}, "polarity");
      chk(puse, use_p, "param use");
      chk({xcfg[5:0], ycfg[5:0]}, use_p ? 12'hE46 : 12'h000, "arming");
      chk({dunsig, zcode}, {md[1], md[1] ? 10'h200 : 10'h000}, "format");
      chk(mon_en, md[2], "monitor");
    end
    for (int f = 0; f < 16; f++)
      if (f[2:1] != 2'h3)
      begin
        wrs(8'h0C, f[7:0]);
        chk(xcfg[12:7], {f[3:0], 1'b1, f[3]}, "filter");
        chk(xcfg.filt_three_pole, f[2:0] == 3'h5, "poles");
      end
    wrs(8'h0B, 8'h08);
    wrs(8'h0D, 8'hF0);
    chk({yst, xst, st_stat, hold, mon_en}, 5'h16, "self-test");
    rd_exp(8'h0D, 8'h80);
    wrs(8'h0D, 8'h00);
    chk({st_stat, hold, mon_en}, 3'h0, "blanked");
    n = 0;
    while (mon_en !== 1'b1 && n < 4 * BLANK)
    begin
      @(posedge clk);
      #2;
      n++;
    end
    chk(n, BLANK, "blank length");
    // Lock with a random configuration; later writes must bounce
    wrs(8'h0C, 8'h80);
    r = $random(seed);
    lock_v = {3'h1, r[4:0]};
    wrs(8'h0B, lock_v);
    chk({idone, crc_en, xst, st_stat}, 4'hC, "lock");
    for (int a = 11; a < 16; a++)
    begin
      r = $random(seed);
      wrs(a[7:0], r[7:0]);
    end
    exp_img = {16'h0639, 8'h00, 8'h80, lock_v};
    chk(img, exp_img, "image");
    for (int i = 0; i < 5; i++)
      rd_exp(8'h0B + i[7:0], exp_img[8*i +: 8]);
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    @(posedge clk);
    #2;
    chk({idone, xst, st_stat}, 3'h0, "after reset");
    rd_exp(8'h0C, 8'h00);
    n = 0;
    while (exp_q.size() != 0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    chk(exp_q.size(), 0, "answers outstanding");
    final_report();
  end
endmodule
